// file: src/mbos_exec.sv
`timescale 1ns/1ps
// Contract
// RULE_01: trap pushes next address, jumps to 0x001, occupies three cycles.
// RULE_02: OR literal into work register, update zero flag, one cycle.
// RULE_03: OR work with register 0..127; dest bit picks work or register; zero flag.
// RULE_04: copy work register into F-page register 5..15, flags untouched, one cycle.
// RULE_05: copy F-page register 5..15 into work register, source and flags kept.
// RULE_06: long jump loads full 11-bit PC from opcode, stack untouched.
// RULE_07: long call pushes next address, bumps pointer, loads target, two cycles.
// RULE_08: return from irq pops PC, decrements pointer, sets irq enable, two cycles.
// RULE_09: zero flag set exactly when 8-bit result is zero, any destination.
// RULE_10: non-branching one-cycle instructions advance PC by exactly one.
module mbos_exec
  import mbos_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire mbos_op_t instrOp,
  input wire logic [DATA_W-1:0] instrLiteral,
  input wire logic [PC_W-1:0] instrTarget,
  input wire logic [RADDR_W-1:0] instrRegAddr,
  input wire logic [FIDX_W-1:0] instrFpageIdx,
  input wire logic instrDest,
  input wire logic [DATA_W-1:0] regRdData,
  output logic instrReady,
  output logic [PC_W-1:0] pc_q,
  output logic [DATA_W-1:0] work_q,
  output logic zero_q,
  output logic gie_q,
  output logic [SP_W-1:0] sp_q,
  output logic regWrEn_q,
  output logic [RADDR_W-1:0] regWrAddr_q,
  output logic [DATA_W-1:0] regWrData_q
);
  mbos_state_t state_q;
  mbos_state_t state_d;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [DATA_W-1:0] fpage_q [16];

  wire logic take = instrValid && instrReady;
  wire logic isTrap = take && instrOp == MBOS_OP_TRAP;
  wire logic isOrLit = take && instrOp == MBOS_OP_OR_LIT;
  wire logic isOrReg = take && instrOp == MBOS_OP_OR_REG;
  wire logic isLoadF = take && instrOp == MBOS_OP_LOAD_FPAGE;
  wire logic isReadF = take && instrOp == MBOS_OP_READ_FPAGE;
  wire logic isJump = take && instrOp == MBOS_OP_LONG_JUMP;
  wire logic isCall = take && instrOp == MBOS_OP_LONG_CALL;
  wire logic isReti = take && instrOp == MBOS_OP_RETURN_IRQ;
  wire logic fpageOk = instrFpageIdx >= FPAGE_FIRST && instrFpageIdx <= FPAGE_LAST;
  wire logic push = isTrap || isCall;
  wire logic [PC_W-1:0] pcNext = pc_q + 11'h001;
  wire logic [SP_W-1:0] spTop = sp_q - 4'h1;
  wire logic [DATA_W-1:0] orLitRes = work_q | instrLiteral; // [RULE_02]
  wire logic [DATA_W-1:0] orRegRes = work_q | regRdData; // [RULE_03]
  wire logic [DATA_W-1:0] orRes = isOrLit ? orLitRes : orRegRes;
  wire logic orToWork = isOrLit || (isOrReg && !instrDest); // [RULE_03]
  wire logic orToReg = isOrReg && instrDest; // [RULE_03]

  // busy states refuse offers outright; nothing is queued, the fetch side re-offers
  assign instrReady = state_q == MBOS_ST_IDLE;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MBOS_ST_IDLE: begin
        if (isTrap) begin
          state_d = MBOS_ST_TRAP2; // [RULE_01]
        end else if (isCall) begin
          state_d = MBOS_ST_CALL2; // [RULE_07]
        end else if (isReti) begin
          state_d = MBOS_ST_RETI2; // [RULE_08]
        end
      end
      MBOS_ST_TRAP2: state_d = MBOS_ST_TRAP3;
      MBOS_ST_TRAP3: state_d = MBOS_ST_IDLE;
      MBOS_ST_CALL2: state_d = MBOS_ST_IDLE;
      MBOS_ST_RETI2: state_d = MBOS_ST_IDLE;
      default: state_d = MBOS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= MBOS_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (isTrap) begin
      pc_q <= TRAP_VECTOR; // [RULE_01]
    end else if (isJump || isCall) begin
      pc_q <= instrTarget; // [RULE_06] [RULE_07]
    end else if (isReti) begin
      pc_q <= stack_q[spTop[2:0]]; // [RULE_08]
    end else if (take) begin
      pc_q <= pcNext; // [RULE_10]
    end
  end

  // overflow wraps silently; depth limits are policed outside this block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_q <= SP_RESET;
    end else if (push) begin
      sp_q <= sp_q + 4'h1; // [RULE_07]
    end else if (isReti) begin
      sp_q <= spTop; // [RULE_08]
    end
  end

  // no reset on the stack: entries only mean something below sp_q
  always_ff @(posedge core_clk) begin
    if (push) begin
      stack_q[sp_q[2:0]] <= pcNext; // [RULE_01] [RULE_07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gie_q <= 1'b0;
    end else if (isReti) begin
      gie_q <= 1'b1; // [RULE_08]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      work_q <= WORK_RESET;
    end else if (orToWork) begin
      work_q <= orRes;
    end else if (isReadF && fpageOk) begin
      work_q <= fpage_q[instrFpageIdx]; // [RULE_05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else if (isOrLit || isOrReg) begin
      zero_q <= orRes == 8'h00; // [RULE_09]
    end
  end

  // out-of-range indices are dropped rather than aliased onto low registers
  always_ff @(posedge core_clk) begin
    if (isLoadF && fpageOk) begin
      fpage_q[instrFpageIdx] <= work_q; // [RULE_04]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regWrEn_q <= 1'b0;
      regWrAddr_q <= 7'h00;
      regWrData_q <= 8'h00;
    end else begin
      regWrEn_q <= orToReg; // [RULE_03]
      regWrAddr_q <= instrRegAddr;
      regWrData_q <= orRes;
    end
  end

  // expectations rebuilt from operands, so a broken datapath wire cannot hide
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_trap_vector_seq: assert property (isTrap |=> pc_q == TRAP_VECTOR && !instrReady ##1 !instrReady ##1 instrReady) // [RULE_01]
    else $error("trap did not reach vector in three cycles");
  chk_trap_push: assert property (isTrap |=> stack_q[$past(sp_q[2:0])] == $past(pcNext)) // [RULE_01]
    else $error("trap return address wrong");
  chk_or_lit_work: assert property (isOrLit |=> work_q == ($past(work_q) | $past(instrLiteral)) && instrReady) // [RULE_02]
    else $error("or literal result wrong");
  chk_or_reg_dest: assert property (isOrReg |=> regWrEn_q == $past(instrDest)
    && (($past(instrDest)) ? work_q == $past(work_q) : work_q == ($past(work_q) | $past(regRdData)))) // [RULE_03]
    else $error("or register destination wrong");
  chk_load_fpage_flags: assert property (isLoadF && fpageOk |=> zero_q == $past(zero_q)
    && fpage_q[$past(instrFpageIdx)] == $past(work_q)) // [RULE_04]
    else $error("fpage load wrong");
  chk_read_fpage_keep: assert property (isReadF && fpageOk |=> work_q == $past(fpage_q[instrFpageIdx]) // [RULE_05]
    && fpage_q[$past(instrFpageIdx)] == $past(fpage_q[instrFpageIdx])
    && zero_q == $past(zero_q))
    else $error("fpage read wrong");
  chk_jump_stack_kept: assert property (isJump |=> pc_q == $past(instrTarget) && $stable(sp_q)) // [RULE_06]
    else $error("long jump wrong");
  chk_call_two_cycles: assert property (isCall |=> pc_q == $past(instrTarget)
    && sp_q == $past(sp_q) + 4'h1 && !instrReady ##1 instrReady) // [RULE_07]
    else $error("long call wrong");
  chk_reti_pop: assert property (isReti |=> gie_q && sp_q == $past(sp_q) - 4'h1 && !instrReady ##1 instrReady) // [RULE_08]
    else $error("return from irq wrong");
  chk_zero_flag_rule: assert property ((isOrLit || isOrReg) |=> zero_q == (($past(work_q) // [RULE_09]
    | ($past(isOrLit) ? $past(instrLiteral) : $past(regRdData))) == 8'h00))
    else $error("zero flag mismatch");
  chk_pc_advance_one: assert property ((isOrLit || isOrReg || isLoadF || isReadF) |=> pc_q == $past(pc_q) + 11'h001) // [RULE_10]
    else $error("pc did not advance by one");
  chk_call_push: assert property (isCall |=> stack_q[$past(sp_q[2:0])] == $past(pc_q) + 11'h001) // [RULE_07]
    else $error("call return address wrong");
  chk_reti_pc_pop: assert property (isReti |=> pc_q == $past(stack_q[sp_q[2:0] - 3'h1])) // [RULE_08]
    else $error("return from irq popped wrong entry");
  chk_reg_write_src: assert property (regWrEn_q |-> $past(isOrReg) && $past(instrDest)) // [RULE_03]
    else $error("register write without or to register");
  chk_fpage_bad_idx: assert property ((isLoadF || isReadF) && !fpageOk |=> // [RULE_04] [RULE_05]
    work_q == $past(work_q) && zero_q == $past(zero_q))
    else $error("bad fpage index not ignored");

  // what an instruction must leave alone
  chk_gie_only_reti: assert property ($rose(gie_q) |-> $past(isReti)) // [RULE_08]
    else $error("irq enable set without return from irq");
  chk_trap_no_flags: assert property (isTrap |=> $stable(work_q) && $stable(zero_q)) // [RULE_01]
    else $error("trap changed work or zero");
  chk_jump_keeps_work: assert property (isJump |=> $stable(work_q) && $stable(zero_q)) // [RULE_06]
    else $error("long jump changed work or zero");
  chk_call_keeps_flags: assert property (isCall |=> $stable(work_q) && $stable(zero_q) && $stable(gie_q)) // [RULE_07]
    else $error("long call changed work or flags");

  // main scenarios
  cov_trap: cover property (isTrap ##3 instrReady);
  cov_call_reti: cover property (isCall ##2 isReti);
  cov_or_reg_to_reg: cover property (isOrReg && instrDest);
  cov_fpage_roundtrip: cover property (isLoadF ##1 isReadF);
  cov_bad_fpage_idx: cover property (isReadF && !fpageOk);
endmodule // mbos_exec

// file: src/mbos_pkg.sv
package mbos_pkg;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int RADDR_W = 7;
  localparam int FIDX_W = 4;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam logic [FIDX_W-1:0] FPAGE_FIRST = 4'h5;
  localparam logic [FIDX_W-1:0] FPAGE_LAST = 4'hf;
  localparam logic [PC_W-1:0] TRAP_VECTOR = 11'h001;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [SP_W-1:0] SP_RESET = 4'h0;
  // cycles per instruction, counted from acceptance
  localparam int TRAP_CYCLES = 3;
  localparam int CALL_CYCLES = 2;
  localparam int RETI_CYCLES = 2;

  typedef enum logic [2:0] {
    MBOS_OP_TRAP = 3'h0,
    MBOS_OP_OR_LIT = 3'h1,
    MBOS_OP_OR_REG = 3'h2,
    MBOS_OP_LOAD_FPAGE = 3'h3,
    MBOS_OP_READ_FPAGE = 3'h4,
    MBOS_OP_LONG_JUMP = 3'h5,
    MBOS_OP_LONG_CALL = 3'h6,
    MBOS_OP_RETURN_IRQ = 3'h7
  } mbos_op_t;

  typedef enum logic [4:0] {
    MBOS_ST_IDLE = 5'b00001,
    MBOS_ST_TRAP2 = 5'b00010,
    MBOS_ST_TRAP3 = 5'b00100,
    MBOS_ST_CALL2 = 5'b01000,
    MBOS_ST_RETI2 = 5'b10000
  } mbos_state_t;
endpackage

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import mbos_pkg::*;
  logic core_clk, rst, instrValid, instrDest, instrReady, zero_q, gie_q, regWrEn_q;
  mbos_op_t instrOp;
  logic [DATA_W-1:0] instrLiteral, regRdData, work_q, regWrData_q, mWork, fp [16];
  logic [PC_W-1:0] instrTarget, pc_q, mPc, stk [STACK_DEPTH];
  logic [RADDR_W-1:0] instrRegAddr, regWrAddr_q;
  logic [FIDX_W-1:0] instrFpageIdx;
  logic [SP_W-1:0] sp_q, mSp;
  logic mZero, mGie;
  int fail_count, check_count;
  mbos_exec i_dut (.core_clk(core_clk), .rst(rst), .instrValid(instrValid), .instrOp(instrOp),
    .instrLiteral(instrLiteral), .instrTarget(instrTarget), .instrRegAddr(instrRegAddr),
    .instrFpageIdx(instrFpageIdx), .instrDest(instrDest), .regRdData(regRdData),
    .instrReady(instrReady), .pc_q(pc_q), .work_q(work_q), .zero_q(zero_q), .gie_q(gie_q),
    .sp_q(sp_q), .regWrEn_q(regWrEn_q), .regWrAddr_q(regWrAddr_q), .regWrData_q(regWrData_q));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic int busy(input mbos_op_t op);
    return op == MBOS_OP_TRAP ? TRAP_CYCLES - 1 :
      (op == MBOS_OP_LONG_CALL || op == MBOS_OP_RETURN_IRQ) ? 1 : 0;
  endfunction
  task automatic issue(input mbos_op_t op, input logic [DATA_W-1:0] lit, input logic [PC_W-1:0] tgt,
      input logic [FIDX_W-1:0] fi, input logic d);
    logic [DATA_W-1:0] rd, res;
    logic [RADDR_W-1:0] ra;
    rd = DATA_W'($urandom);
    ra = RADDR_W'($urandom);
    @(posedge core_clk);
    instrValid <= 1'b1;
    instrOp <= op;
    instrLiteral <= lit;
    instrTarget <= tgt;
    instrRegAddr <= ra;
    instrFpageIdx <= fi;
    instrDest <= d;
    regRdData <= rd;
    @(posedge core_clk);
    instrValid <= 1'b0;
    #1;
    res = mWork | (op == MBOS_OP_OR_LIT ? lit : rd);
    case (op)
      MBOS_OP_TRAP, MBOS_OP_LONG_CALL: begin
        stk[mSp[2:0]] = mPc + 1'b1;
        mSp++;
        mPc = op == MBOS_OP_TRAP ? TRAP_VECTOR : tgt;
      end
      MBOS_OP_LONG_JUMP: mPc = tgt;
      MBOS_OP_RETURN_IRQ: begin
        mSp--;
        mPc = stk[mSp[2:0]];
        mGie = 1'b1;
      end
      default: begin
        mPc++;
        if (op == MBOS_OP_OR_LIT || op == MBOS_OP_OR_REG) mZero = res == 8'h00;
        if (op == MBOS_OP_OR_LIT || (op == MBOS_OP_OR_REG && !d)) mWork = res;
        if (op == MBOS_OP_LOAD_FPAGE && fi >= FPAGE_FIRST) fp[fi] = mWork;
        if (op == MBOS_OP_READ_FPAGE && fi >= FPAGE_FIRST) mWork = fp[fi];
      end
    endcase
    check(pc_q, mPc);
    check(work_q, mWork);
    check(zero_q, mZero);
    check(sp_q, mSp);
    check(gie_q, mGie);
    check(regWrEn_q, op == MBOS_OP_OR_REG && d);
    if (op == MBOS_OP_OR_REG && d) check({regWrAddr_q, regWrData_q}, {ra, res});
    for (int i = 0; i < busy(op); i++) begin
      check(instrReady, 1'b0);
      @(posedge core_clk);
      #1;
    end
    check(instrReady, 1'b1);
  endtask
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end
  initial begin
    mbos_op_t op;
    void'($urandom(28431));
    {rst, instrValid, instrDest, instrLiteral, regRdData, instrTarget} = '1;
    {instrRegAddr, instrFpageIdx} = '0;
    instrOp = MBOS_OP_OR_LIT;
    {mPc, mWork, mZero, mGie, mSp} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    instrValid <= 1'b0;
    #1;
    check({pc_q, work_q, zero_q, gie_q, sp_q, regWrEn_q}, '0);
    issue(MBOS_OP_OR_LIT, 8'h00, '0, '0, 1'b0); // zero result sets the flag
    for (int i = 5; i < 16; i++) begin
      issue(MBOS_OP_OR_LIT, DATA_W'($urandom), '0, '0, 1'b0);
      issue(MBOS_OP_LOAD_FPAGE, '0, '0, FIDX_W'(i), 1'b0);
    end
    for (int i = 0; i < 16; i++) issue(MBOS_OP_READ_FPAGE, '0, '0, FIDX_W'(i), 1'b0);
    issue(MBOS_OP_LONG_JUMP, '0, 11'h7ff, '0, 1'b0);
    issue(MBOS_OP_LONG_CALL, '0, 11'h7ff, '0, 1'b0);
    for (int n = 0; n < 400; n++) begin
      op = mbos_op_t'($urandom % 8);
      if (op == MBOS_OP_RETURN_IRQ && mSp == 0) op = MBOS_OP_LONG_CALL;
      // keep the stack inside its depth, wrap is not modelled
      if ((op == MBOS_OP_TRAP || op == MBOS_OP_LONG_CALL) && mSp >= 6) op = MBOS_OP_RETURN_IRQ;
      issue(op, DATA_W'($urandom), PC_W'($urandom), FIDX_W'($urandom), 1'($urandom));
    end
    print_verdict();
  end
endmodule // tb
